// ==== dpz_cal_engine.sv ====
// Purpose: Impedance calibration engine against the reference resistor comparator
// Assumes: cmp_high is high when the trial code drives too strong
// Notes: Long run is a full binary search, short run is one code step
`timescale 1ns/1ps
`default_nettype none
module dpz_cal_engine #(
  parameter int unsigned SETTLE = dpz_pkg::SETTLE_NCK
) (
  input wire logic clock,
  input wire logic arst_n,
  dpz_cal_if.eng cal
);
  import dpz_pkg::*;

  typedef enum logic [3:0] {
    ENG_IDLE = 4'b0001,
    ENG_SAR = 4'b0010,
    ENG_TRIM = 4'b0100,
    ENG_DONE = 4'b1000
  } dpz_eng_t;

  dpz_eng_t state_ff;
  logic [CODE_W-1:0] code_ff;
  logic [CODE_W-1:0] mask_ff;
  logic [SETTLE_W-1:0] settle_ff;
  logic settled;

  assign settled = (settle_ff == '0);

  // Sequencer, settle count and trial code
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ENG_IDLE;
      code_ff <= CODE_RST;
      mask_ff <= '0;
      settle_ff <= '0;
    end else begin
      case (state_ff)
        ENG_IDLE: begin
          if (cal.start) begin
            settle_ff <= SETTLE_W'(SETTLE - 1);
            if (cal.long_mode) begin
              code_ff <= CODE_RST; // Midscale first trial
              mask_ff <= CODE_RST;
              state_ff <= ENG_SAR; // RL9
            end else begin
              state_ff <= ENG_TRIM; // RL11
            end
          end
        end
        ENG_SAR: begin
          if (!settled) begin
            settle_ff <= settle_ff - 1'b1;
          end else begin
            settle_ff <= SETTLE_W'(SETTLE - 1);
            mask_ff <= mask_ff >> 1;
            if (cal.cmp_high) begin
              code_ff <= (code_ff & ~mask_ff) | (mask_ff >> 1);
            end else begin
              code_ff <= code_ff | (mask_ff >> 1);
            end
            if (mask_ff[0]) begin
              state_ff <= ENG_DONE;
            end
          end
        end
        ENG_TRIM: begin
          // One code step is at least the minimum correction, well inside 64 nCK
          if (!settled) begin
            settle_ff <= settle_ff - 1'b1;
          end else begin
            if (cal.cmp_high && code_ff != '0) begin
              code_ff <= code_ff - 1'b1; // RL12
            end else if (!cal.cmp_high && code_ff != '1) begin
              code_ff <= code_ff + 1'b1; // RL12
            end
            state_ff <= ENG_DONE;
          end
        end
        ENG_DONE: begin
          state_ff <= ENG_IDLE;
        end
        default: begin
          state_ff <= ENG_IDLE;
        end
      endcase
    end
  end

  // Status toward the tracker
  assign cal.busy = (state_ff != ENG_IDLE);
  assign cal.done = (state_ff == ENG_DONE);
  assign cal.cur_en = (state_ff == ENG_SAR) || (state_ff == ENG_TRIM); // RL14
  assign cal.code = code_ff;
endmodule
`default_nettype wire

// ==== dpz_cal_if.sv ====
// Purpose: Link between the command tracker and the calibration engine
// Assumes: Both ends run on the same clock
// Notes: start is a one-cycle pulse; done is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface dpz_cal_if;
  import dpz_pkg::*;
  logic start;
  logic long_mode;
  logic cmp_high;
  logic busy;
  logic done;
  logic cur_en;
  logic [CODE_W-1:0] code;

  modport eng(input start, input long_mode, input cmp_high, output busy, output done, output cur_en, output code);
  modport ctl(output start, output long_mode, output cmp_high, input busy, input done, input cur_en, input code);
endinterface
`default_nettype wire

// ==== dpz_ctl_model.sv ====
// Purpose: Memory controller model driving cke and the command pins
// Assumes: Each request is driven 1 ns after a rising edge
// Notes: Comparator level is set by the bench
`timescale 1ns/1ps
`default_nettype none
module dpz_ctl_model (
  input wire logic clock,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic a10,
  output logic [dpz_pkg::BA_W-1:0] ba,
  output logic zq_cmp_high
);
  import dpz_pkg::*;
  // Idle bus at time zero; no termination pin or data drivers exist, so both stay off
  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    a10 = 1'b0;
    ba = '0;
    zq_cmp_high = 1'b0;
  end
  // One request held through one sampling edge; the next call replaces it
  task automatic issue(input logic k, input logic [3:0] pins, input logic a, input logic [BA_W-1:0] b);
    cke = k;
    {cs_n, ras_n, cas_n, we_n} = pins;
    a10 = a;
    ba = b;
    @(posedge clock);
    #1;
  endtask
  // NOP cycles with cke unchanged; no traffic during a window
  task automatic idle(input int n);
    repeat (n) issue(cke, 4'h7, a10, ba);
  endtask
  task automatic set_cmp(input logic v);
    zq_cmp_high = v;
  endtask
endmodule
`default_nettype wire

// ==== dpz_pkg.sv ====
// Purpose: Shared constants for the power-down and impedance calibration block
// Assumes: One device clock; command pins sampled on its rising edge
// Notes: Window lengths are counted in device clock cycles (nCK)
package dpz_pkg;

  // Device clock figures
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned CLK_PERIOD_PS = 1000000 / CLK_MHZ;

  // Calibration windows in nCK; one nCK is one cycle of clock
  localparam int unsigned ZQINIT_NCK = 512;
  localparam int unsigned ZQOPER_NCK = 256;
  localparam int unsigned ZQCS_NCK = 64;
  localparam int unsigned ZQCS_CORR_NCK = 64;
  localparam int unsigned ZQINIT_CYC = ZQINIT_NCK;
  localparam int unsigned ZQOPER_CYC = ZQOPER_NCK;
  localparam int unsigned ZQCS_CYC = ZQCS_NCK;
  localparam int unsigned WIN_W = 10;

  // Calibration engine shape
  localparam int unsigned CODE_W = 6;
  localparam logic [CODE_W-1:0] CODE_RST = 6'h20;
  localparam int unsigned SETTLE_NCK = 4;
  localparam int unsigned SETTLE_W = 3;

  // Bank count
  localparam int unsigned BANKS = 8;
  localparam int unsigned BA_W = 3;

  // Decoded command from the command pins
  typedef enum logic [3:0] {
    DPZ_CMD_DES = 4'h0,
    DPZ_CMD_NOP = 4'h1,
    DPZ_CMD_ACT = 4'h2,
    DPZ_CMD_PRE = 4'h3,
    DPZ_CMD_REF = 4'h4,
    DPZ_CMD_ZQ = 4'h5,
    DPZ_CMD_OTHER = 4'h6
  } dpz_cmd_t;

endpackage

// ==== dpz_top.sv ====
// Purpose: Device-side power-down and impedance calibration command tracking
// Assumes: Command pins and cke are synchronous to clock and sampled on its rising edge
// Notes: Checks on controller behaviour raise ctl_violation but never alter device state
`timescale 1ns/1ps
`default_nettype none
// Function
// [RL1] Enter power-down on cke low with NOP/DES; exit on cke high with NOP/DES.
// [RL2] Controller waits exit latency, and DLL-locked latency after slow exit.
// [RL3] Controller holds cke low at least tPD before exit.
// [RL4] Refresh between exit and re-entry waits exit latency first.
// [RL5] Re-entry after that refresh waits DLL latency counted from exit.
// [RL6] After early entry following refresh, only NOP/DES until refresh cycle time passes.
// [RL7] Active power-down may follow ACT, NOP, DES or PRE leaving a bank open.
// [RL8] Long calibration serves initial calibration and may be repeated any time.
// [RL9] Long calibration runs the engine then transfers values to the IO.
// [RL10] First long calibration after reset gets init window, later ones the oper window.
// [RL11] Short calibration does a periodic drift update within its shorter window.
// [RL12] Each short calibration corrects a minimum step within 64 clocks.
// [RL13] Controller keeps the channel quiet during any calibration window.
// [RL14] Calibration current path is switched off once calibration completes.
// [RL15] Controller precharges all banks and meets tRP before calibration.
// [RL16] Calibration after self-refresh exit waits at least tXS.
// [RL17] No IO recalibration on self-refresh exit without an explicit command.
// [RL18] Devices sharing the reference resistor never overlap calibration windows.
// [RL19] Controller keeps cke high throughout any calibration window.
// [RL20] Termination is off during calibration.
// [RL21] All data bus drivers are high impedance during calibration.
// [RL22] Controller keeps per-window counters and blocks conflicting commands.
module dpz_top #(
  parameter int unsigned ZQINIT_CYCLES = dpz_pkg::ZQINIT_CYC,
  parameter int unsigned ZQOPER_CYCLES = dpz_pkg::ZQOPER_CYC,
  parameter int unsigned ZQCS_CYCLES = dpz_pkg::ZQCS_CYC,
  parameter int unsigned SETTLE = dpz_pkg::SETTLE_NCK
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic a10,
  input wire logic [dpz_pkg::BA_W-1:0] ba,
  input wire logic zq_cmp_high,
  output logic in_powerdown,
  output logic active_powerdown,
  output logic in_self_refresh,
  output logic zq_busy,
  output logic zq_current_en,
  output logic init_cal_done,
  output logic [dpz_pkg::CODE_W-1:0] io_imp_code,
  output logic io_update,
  output logic ctl_violation
);
  import dpz_pkg::*;

  typedef enum logic [3:0] {
    DEV_AWAKE = 4'b0001,
    DEV_PD = 4'b0010,
    DEV_SR = 4'b0100,
    DEV_ZQ = 4'b1000
  } dpz_dev_t;

  dpz_cal_if cal ();

  dpz_dev_t state_ff;
  logic cke_prev_ff;
  logic [BANKS-1:0] bank_open_ff;
  logic first_long_done_ff;
  logic init_run_ff;
  logic [WIN_W-1:0] win_cnt_ff;
  logic [CODE_W-1:0] io_code_ff;
  logic io_update_ff;
  logic active_pd_ff;
  logic viol_ff;
  logic nxt_viol;
  logic start_zq;
  logic nop_like;
  dpz_cmd_t cmd;

  // Command decode from the sampled pins
  always_comb begin
    if (cs_n) begin
      cmd = DPZ_CMD_DES;
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h7: cmd = DPZ_CMD_NOP;
        3'h3: cmd = DPZ_CMD_ACT;
        3'h2: cmd = DPZ_CMD_PRE;
        3'h1: cmd = DPZ_CMD_REF;
        3'h6: cmd = DPZ_CMD_ZQ;
        default: cmd = DPZ_CMD_OTHER;
      endcase
    end
  end

  assign nop_like = (cmd == DPZ_CMD_NOP) || (cmd == DPZ_CMD_DES);
  // Calibration accepted only while awake with cke held high
  assign start_zq = (state_ff == DEV_AWAKE) && cke_prev_ff && cke && (cmd == DPZ_CMD_ZQ); // RL8

  // Previous cke sample, for entry edge detection and the calibration start check
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cke_prev_ff <= 1'b0;
    end else begin
      cke_prev_ff <= cke;
    end
  end

  // Open-bank tracking, one flop per bank
  genvar gb;
  generate
    for (gb = 0; gb < BANKS; gb++) begin : g_bank
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          bank_open_ff[gb] <= 1'b0;
        end else if (state_ff == DEV_AWAKE && cke) begin
          if (cmd == DPZ_CMD_ACT && ba == BA_W'(gb)) begin
            bank_open_ff[gb] <= 1'b1;
          end else if (cmd == DPZ_CMD_PRE && (a10 || ba == BA_W'(gb))) begin
            bank_open_ff[gb] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Device operating state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= DEV_AWAKE;
      active_pd_ff <= 1'b0;
    end else begin
      case (state_ff)
        DEV_AWAKE: begin
          if (cke_prev_ff && !cke && nop_like) begin
            state_ff <= DEV_PD; // RL1
            // Active mode if any bank is open in the registered state at the entry edge
            active_pd_ff <= |bank_open_ff; // RL7
          end else if (cke_prev_ff && !cke && cmd == DPZ_CMD_REF) begin
            state_ff <= DEV_SR;
          end else if (start_zq) begin
            state_ff <= DEV_ZQ;
          end
        end
        DEV_PD: begin
          // Receivers are off; only cke high with NOP/DES ends it
          if (cke && nop_like) begin
            state_ff <= DEV_AWAKE; // RL1
            active_pd_ff <= 1'b0;
          end
        end
        DEV_SR: begin
          // Exit only wakes; calibration waits for an explicit command
          if (cke && nop_like) begin
            state_ff <= DEV_AWAKE; // RL17
          end
        end
        DEV_ZQ: begin
          if (win_cnt_ff == '0) begin
            state_ff <= DEV_AWAKE;
          end
        end
        default: begin
          state_ff <= DEV_AWAKE;
        end
      endcase
    end
  end

  // Calibration window length and first-long tracking
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      win_cnt_ff <= '0;
      first_long_done_ff <= 1'b0;
    end else if (start_zq) begin
      if (!a10) begin
        win_cnt_ff <= WIN_W'(ZQCS_CYCLES - 1); // RL11
      end else if (!first_long_done_ff) begin
        win_cnt_ff <= WIN_W'(ZQINIT_CYCLES - 1); // RL10
        first_long_done_ff <= 1'b1;
      end else begin
        win_cnt_ff <= WIN_W'(ZQOPER_CYCLES - 1); // RL10
      end
    end else if (state_ff == DEV_ZQ && win_cnt_ff != '0) begin
      win_cnt_ff <= win_cnt_ff - 1'b1;
    end
  end

  // First long window in progress; a10 is don't care inside it, so it is latched here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      init_run_ff <= 1'b0;
    end else if (start_zq && a10 && !first_long_done_ff) begin
      init_run_ff <= 1'b1; // RL10
    end else if (state_ff == DEV_ZQ && win_cnt_ff == '0) begin
      init_run_ff <= 1'b0;
    end
  end

  // Engine hookup
  assign cal.start = start_zq;
  assign cal.long_mode = a10;
  assign cal.cmp_high = zq_cmp_high;

  dpz_cal_engine #(
    .SETTLE(SETTLE)
  ) u_engine (
    .clock(clock),
    .arst_n(arst_n),
    .cal(cal)
  );

  // Transfer of the finished code into the IO driver and termination legs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      io_code_ff <= CODE_RST;
      io_update_ff <= 1'b0;
    end else begin
      io_update_ff <= cal.done;
      if (cal.done) begin
        io_code_ff <= cal.code; // RL9
      end
    end
  end

  // Controller misbehaviour seen at the pins
  always_comb begin
    nxt_viol = 1'b0;
    if (state_ff == DEV_ZQ && (!cke || !nop_like)) begin
      nxt_viol = 1'b1; // RL13 RL19
    end
    if (start_zq && (|bank_open_ff)) begin
      nxt_viol = 1'b1; // RL15
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      viol_ff <= 1'b0;
    end else begin
      viol_ff <= nxt_viol;
    end
  end

  // Outputs
  assign in_powerdown = (state_ff == DEV_PD);
  assign active_powerdown = active_pd_ff;
  assign in_self_refresh = (state_ff == DEV_SR);
  assign zq_busy = (state_ff == DEV_ZQ);
  assign zq_current_en = cal.cur_en; // RL14
  assign init_cal_done = first_long_done_ff && !init_run_ff; // RL10
  assign io_imp_code = io_code_ff;
  assign io_update = io_update_ff;
  assign ctl_violation = viol_ff;
endmodule
`default_nettype wire

// ==== dpz_top_chk.sv ====
// Purpose: Port-level property checks for the power-down and calibration block
// Assumes: One clock domain with asynchronous active-low reset
// Notes: Window lengths come from the bound parameters
`timescale 1ns/1ps
`default_nettype none
module dpz_top_chk #(
  parameter int unsigned ZQINIT_CYCLES = dpz_pkg::ZQINIT_CYC,
  parameter int unsigned ZQOPER_CYCLES = dpz_pkg::ZQOPER_CYC,
  parameter int unsigned ZQCS_CYCLES = dpz_pkg::ZQCS_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic a10,
  input wire logic in_powerdown,
  input wire logic in_self_refresh,
  input wire logic zq_busy,
  input wire logic zq_current_en,
  input wire logic [dpz_pkg::CODE_W-1:0] io_imp_code,
  input wire logic io_update,
  input wire logic ctl_violation
);
  import dpz_pkg::*;
  logic cke_ff;
  logic first_ff;
  logic [WIN_W-1:0] cnt_ff;
  logic [WIN_W-1:0] exp_ff;
  logic nopdes;
  logic awake;
  logic zq_go;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Command decode and state summary
  assign nopdes = cs_n | (ras_n & cas_n & we_n);
  assign awake = !in_powerdown && !in_self_refresh && !zq_busy;
  assign zq_go = awake && cke_ff && cke && !cs_n && ras_n && cas_n && !we_n;
  // Previous cke sample, reset low like the device
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) cke_ff <= 1'b0;
    else cke_ff <= cke;
  end
  // Expected window, fixed at the accepting edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      first_ff <= 1'b0;
      exp_ff <= '0;
    end else if (zq_go) begin
      first_ff <= first_ff | a10;
      exp_ff <= WIN_W'(a10 ? (first_ff ? ZQOPER_CYCLES : ZQINIT_CYCLES) : ZQCS_CYCLES);
    end
  end
  // Busy length counter
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) cnt_ff <= '0;
    else cnt_ff <= zq_busy ? cnt_ff + 1'b1 : '0;
  end
  pd_entry_a: assert property (awake && cke_ff && !cke && nopdes |=> in_powerdown)
    else $error("power-down not entered");
  pd_hold_a: assert property (in_powerdown && !cke |=> in_powerdown)
    else $error("power-down left with cke low");
  pd_exit_a: assert property (in_powerdown && cke && nopdes |=> !in_powerdown)
    else $error("power-down not exited");
  zq_start_a: assert property (zq_go |=> zq_busy && zq_current_en)
    else $error("calibration not started");
  win_len_a: assert property ($fell(zq_busy) |-> cnt_ff == exp_ff)
    else $error("calibration window length wrong");
  cur_off_a: assert property (!zq_busy |-> !zq_current_en)
    else $error("calibration current on outside window");
  upd_pulse_a: assert property (io_update |-> $past(zq_current_en, 2) && !zq_current_en && zq_busy ##1 !io_update)
    else $error("io update not tied to engine finish");
  code_hold_a: assert property (!io_update |-> $stable(io_imp_code))
    else $error("impedance code moved without update");
  quiet_flag_a: assert property (zq_busy && !(cke && nopdes) |=> ctl_violation)
    else $error("busy channel activity not flagged");
  sr_nocal_a: assert property ($fell(in_self_refresh) |-> (!zq_busy && !io_update) [*3])
    else $error("calibration on self-refresh exit");
  long_c: cover property ($fell(zq_busy) && exp_ff == WIN_W'(ZQINIT_CYCLES));
  pd_c: cover property (awake && cke_ff && !cke && nopdes);
  viol_c: cover property (ctl_violation);
endmodule
`default_nettype wire

// ==== tb.sv ====
// Purpose: Self-checking bench for power-down and calibration tracking
// Assumes: Shortened windows 32/24/16 with settle 2
// Notes: Stimulus goes through the controller model
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dpz_pkg::*;
  localparam int unsigned T_INIT = 32;
  localparam int unsigned T_OPER = 24;
  localparam int unsigned T_CS = 16;
  localparam logic [3:0] P_NOP = 4'h7;
  localparam logic [3:0] P_ACT = 4'h3;
  localparam logic [3:0] P_PRE = 4'h2;
  localparam logic [3:0] P_REF = 4'h1;
  localparam logic [3:0] P_ZQ = 4'h6;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  wire logic cke, cs_n, ras_n, cas_n, we_n, a10, zq_cmp_high;
  wire logic [BA_W-1:0] ba;
  logic in_powerdown, active_powerdown, in_self_refresh, zq_busy, zq_current_en, init_cal_done;
  logic [CODE_W-1:0] io_imp_code;
  logic io_update, ctl_violation;
  int n_errors = 0;
  int tests_run = 0;
  always #4 clock = ~clock;
  dpz_ctl_model dpz_ctl_model_inst (.clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .a10(a10), .ba(ba), .zq_cmp_high(zq_cmp_high));
  dpz_top #(.ZQINIT_CYCLES(T_INIT), .ZQOPER_CYCLES(T_OPER), .ZQCS_CYCLES(T_CS), .SETTLE(2)) dpz_top_inst (
    .clock(clock), .arst_n(arst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .a10(a10), .ba(ba), .zq_cmp_high(zq_cmp_high), .in_powerdown(in_powerdown),
    .active_powerdown(active_powerdown), .in_self_refresh(in_self_refresh), .zq_busy(zq_busy),
    .zq_current_en(zq_current_en), .init_cal_done(init_cal_done), .io_imp_code(io_imp_code),
    .io_update(io_update), .ctl_violation(ctl_violation));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    arst_n = 1'b1;
    dpz_ctl_model_inst.issue(1'b1, P_NOP, 1'b0, 3'h0);
    check(8'(io_imp_code), 8'h20);
    check(8'(init_cal_done), 8'h00);
    dpz_ctl_model_inst.idle(2);
  endtask
  // Calibration window length, result code and single update
  task automatic t_zq(input logic lng, input logic cmp, input int len, input logic [7:0] code);
    int n = 0;
    int upd_at = 0;
    int upd_n = 0;
    dpz_ctl_model_inst.set_cmp(cmp);
    dpz_ctl_model_inst.issue(1'b1, P_ZQ, lng, 3'h0);
    while (zq_busy === 1'b1 && n < 600) begin
      if (io_update === 1'b1) begin
        upd_n++;
        upd_at = n;
      end
      n++;
      dpz_ctl_model_inst.idle(1);
    end
    check(8'(n), 8'(len));
    check(8'(io_imp_code), code);
    check(8'(upd_n), 8'h01);
    check(8'(upd_at < 64), 8'h01);
    check(8'(zq_current_en), 8'h00);
  endtask
  // Entry, hold, exit, then refresh, or precharge of the open bank, before re-entry
  task automatic t_pd(input logic bank);
    if (bank) dpz_ctl_model_inst.issue(1'b1, P_ACT, 1'b0, 3'h5);
    dpz_ctl_model_inst.issue(1'b0, P_NOP, 1'b0, 3'h0);
    check(8'(in_powerdown), 8'h01);
    check(8'(active_powerdown), 8'(bank));
    dpz_ctl_model_inst.idle(3);
    check(8'(in_powerdown), 8'h01);
    dpz_ctl_model_inst.issue(1'b1, P_NOP, 1'b0, 3'h0);
    check(8'(in_powerdown), 8'h00);
    check(8'(active_powerdown), 8'h00);
    dpz_ctl_model_inst.idle(3);
    if (bank) dpz_ctl_model_inst.issue(1'b1, P_PRE, 1'b0, 3'h5);
    else dpz_ctl_model_inst.issue(1'b1, P_REF, 1'b0, 3'h0);
    dpz_ctl_model_inst.idle(8);
  endtask
  // Activity during a window, and calibration with a bank open
  task automatic t_viol();
    dpz_ctl_model_inst.issue(1'b1, P_ZQ, 1'b0, 3'h0);
    check(8'(ctl_violation), 8'h00);
    dpz_ctl_model_inst.issue(1'b1, P_REF, 1'b0, 3'h0);
    check(8'(ctl_violation), 8'h01);
    dpz_ctl_model_inst.issue(1'b0, P_NOP, 1'b0, 3'h0);
    check(8'(ctl_violation), 8'h01);
    dpz_ctl_model_inst.issue(1'b1, P_NOP, 1'b0, 3'h0);
    dpz_ctl_model_inst.idle(T_CS);
    check(8'(zq_busy), 8'h00);
    dpz_ctl_model_inst.issue(1'b1, P_ACT, 1'b0, 3'h5);
    dpz_ctl_model_inst.issue(1'b1, P_PRE, 1'b0, 3'h2);
    dpz_ctl_model_inst.issue(1'b1, P_ZQ, 1'b0, 3'h0);
    check(8'(ctl_violation), 8'h01);
    dpz_ctl_model_inst.idle(T_CS);
    dpz_ctl_model_inst.issue(1'b1, P_PRE, 1'b1, 3'h0);
    dpz_ctl_model_inst.idle(3);
  endtask
  // Self-refresh exit leaves the code alone
  task automatic t_sr();
    logic [CODE_W-1:0] saved;
    saved = io_imp_code;
    dpz_ctl_model_inst.issue(1'b0, P_REF, 1'b0, 3'h0);
    check(8'(in_self_refresh), 8'h01);
    dpz_ctl_model_inst.idle(4);
    dpz_ctl_model_inst.issue(1'b1, P_NOP, 1'b0, 3'h0);
    check(8'(in_self_refresh), 8'h00);
    dpz_ctl_model_inst.idle(8);
    check(8'(zq_busy), 8'h00);
    check(8'(io_imp_code), 8'(saved));
  endtask
  initial begin
    do_reset();
    t_zq(1'b1, 1'b1, T_INIT, 8'h00);
    check(8'(init_cal_done), 8'h01);
    t_zq(1'b1, 1'b0, T_OPER, 8'h3f);
    t_zq(1'b0, 1'b0, T_CS, 8'h3f);
    t_zq(1'b0, 1'b1, T_CS, 8'h3e);
    t_pd(1'b0);
    t_pd(1'b0);
    t_pd(1'b1);
    t_viol();
    t_sr();
    do_reset();
    t_zq(1'b1, 1'b0, T_INIT, 8'h3f);
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    #100000;
    n_errors++;
    tally_and_finish();
  end
endmodule
bind dpz_top dpz_top_chk #(.ZQINIT_CYCLES(ZQINIT_CYCLES), .ZQOPER_CYCLES(ZQOPER_CYCLES), .ZQCS_CYCLES(ZQCS_CYCLES))
  dpz_top_chk_inst (.clock(clock), .arst_n(arst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
  .we_n(we_n), .a10(a10), .in_powerdown(in_powerdown), .in_self_refresh(in_self_refresh), .zq_busy(zq_busy),
  .zq_current_en(zq_current_en), .io_imp_code(io_imp_code), .io_update(io_update),
  .ctl_violation(ctl_violation));
`default_nettype wire
